// ===== src/ecmc_top.sv
// Mode control around the echo estimator, with a Wishbone slave.
// Assumes pins are asynchronous to I_CLK and the load detect output
// is wired back to the interrupt input.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ecmc_top
    import ecmc_pkg::*;
#(
    parameter int unsigned DEPTH = 256
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_SCK,
    input  wire logic        I_SYNC,
    input  wire logic        I_TX_SERIAL_IN,
    input  wire logic        I_RX_SERIAL_IN,
    input  wire logic        I_INT_N,
    input  wire logic        I_CENTER_CLIP_CTL,
    input  wire logic        I_THROUGH_MODE_CTL,
    input  wire logic        I_COEF_FREEZE_CTL,
    input  wire logic        I_ROLE_SELECT,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    output logic             O_TX_SERIAL_OUT,
    output logic             O_RX_SERIAL_OUT,
    output logic             O_LOAD_DETECT_N,
    output ecmc_mode_t       O_MODE
);

    localparam logic [4:0] PIN_RST = 5'h10;

    logic [4:0]             pin_s1_q;
    logic [4:0]             pin_s2_q;
    logic                   int_s3_q;
    logic                   int_go;
    logic                   boot_latch;
    logic [INIT_W-1:0]      init_cnt_q;
    logic                   init_done;
    ecmc_mode_t             mode_in;
    ecmc_mode_t             mode_q;
    logic                   start_q;

    logic [2:0]             itg_q;
    logic                   in_new;
    ecmc_pcm_pair_t         link_in;
    logic                   link_tgl;
    ecmc_pcm_pair_t         pair_in_q;
    ecmc_pcm_pair_t         proc_q;
    ecmc_pcm_pair_t         out_q;
    logic                   out_tgl_q;
    logic [2:0]             ld_cnt_q;

    logic [TAP_W-1:0]       taps;
    logic signed [LIN_W-1:0] fir_err;
    logic                   fir_busy;
    logic                   fir_done;
    logic                   clip_hit;

    logic [LIN_W-1:0]       thr_q;
    logic                   wb_hit;
    logic [31:0]            status;

    // Pin synchronisers; the interrupt idles high
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pin_s1_q <= PIN_RST;
            pin_s2_q <= PIN_RST;
            int_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= {I_INT_N, I_CENTER_CLIP_CTL, I_THROUGH_MODE_CTL,
                         I_COEF_FREEZE_CTL, I_ROLE_SELECT};
            pin_s2_q <= pin_s1_q;
            int_s3_q <= pin_s2_q[4];
        end
    end

    // Initialisation window after reset
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            init_cnt_q <= '0;
        end else if (!init_done) begin
            init_cnt_q <= init_cnt_q + 1'b1;
        end
    end

    assign init_done  = (init_cnt_q == INIT_W'(INIT_CYC));
    // Wait for the synchronisers to fill before the reset latch
    assign boot_latch = (init_cnt_q == INIT_W'(INIT_LATCH));
    assign int_go     = int_s3_q & ~pin_s2_q[4] & init_done;

    always_comb begin
        mode_in         = ecmc_mode_t'(pin_s2_q[3:0]);
        // A slave never clips even if its pin is left floating high
        mode_in.clip    = pin_s2_q[3] & ~pin_s2_q[0];
        mode_in.through = pin_s2_q[2];
        mode_in.freeze  = pin_s2_q[1];
        mode_in.slave   = pin_s2_q[0];
    end

    // Mode changes only here, so a period never sees a mid-run switch
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_q <= MODE_RST;
        end else if (boot_latch || int_go) begin
            mode_q <= mode_in;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_MODE <= MODE_RST;
        end else begin
            O_MODE <= mode_q;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            start_q <= 1'b0;
        end else begin
            start_q <= int_go;
        end
    end

    // Received words cross in by toggle; the word is stable by then
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            itg_q     <= '0;
            pair_in_q <= {MU_IDLE, MU_IDLE};
        end else begin
            itg_q <= {itg_q[1:0], link_tgl};
            if (in_new) pair_in_q <= link_in;
        end
    end

    assign in_new = itg_q[2] ^ itg_q[1];

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ld_cnt_q        <= '0;
            O_LOAD_DETECT_N <= 1'b1;
        end else begin
            if (in_new)
                ld_cnt_q <= LOAD_CYC;
            else if (ld_cnt_q != '0)
                ld_cnt_q <= ld_cnt_q - 3'h1;
            O_LOAD_DETECT_N <= ~(in_new | (ld_cnt_q > 3'h1));
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            proc_q <= {MU_IDLE, MU_IDLE};
        end else if (start_q) begin
            proc_q <= pair_in_q;
        end
    end

    // Slave covers a longer span; cascade length is set by the board
    assign taps = mode_q.slave ? TAP_W'(SLAVE_TAPS)
                               : TAP_W'(MASTER_TAPS);

    ecmc_fir #(
        .DEPTH (DEPTH)
    ) u_fir (
        .clk      (I_CLK),
        .rst      (I_RESET),
        .i_start  (start_q),
        .i_clear  (mode_q.through),
        .i_freeze (mode_q.freeze | mode_q.through),
        .i_taps   (taps),
        .i_x      (ecmc_mu_expand(pair_in_q.rx)),
        .i_y      (ecmc_mu_expand(pair_in_q.tx)),
        .o_err    (fir_err),
        .o_busy   (fir_busy),
        .o_done   (fir_done)
    );

    assign clip_hit = mode_q.clip && (ecmc_abs(fir_err) < thr_q);

    // Output words cross out by toggle, one pair per period
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            out_q     <= {MU_IDLE, MU_IDLE};
            out_tgl_q <= 1'b0;
        end else if (fir_done) begin
            out_tgl_q <= ~out_tgl_q;
            if (mode_q.through) begin
                out_q <= proc_q;
            end else begin
                out_q.rx <= proc_q.rx;
                out_q.tx <= clip_hit ? MU_IDLE
                                     : ecmc_mu_compress(fir_err);
            end
        end
    end

    ecmc_link u_link (
        .i_sck     (I_SCK),
        .i_rst     (I_RESET),
        .i_sync    (I_SYNC),
        .i_tx_in   (I_TX_SERIAL_IN),
        .i_rx_in   (I_RX_SERIAL_IN),
        .i_out     (out_q),
        .i_out_tgl (out_tgl_q),
        .o_in      (link_in),
        .o_in_tgl  (link_tgl),
        .o_tx_out  (O_TX_SERIAL_OUT),
        .o_rx_out  (O_RX_SERIAL_OUT)
    );

    // Wishbone slave, one wait state, unmapped reads return zero
    assign wb_hit = I_WB_CYC & I_WB_STB & ~O_WB_ACK;

    always_comb begin
        status          = 32'h0000_0000;
        status[3:0]     = mode_q;
        status[ST_INIT] = init_done;
        status[ST_BUSY] = fir_busy;
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_WB_ACK <= 1'b0;
        end else begin
            O_WB_ACK <= wb_hit;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_WB_DAT <= 32'h0000_0000;
        end else if (wb_hit && !I_WB_WE) begin
            case (I_WB_ADR)
                REG_CTRL:   O_WB_DAT <= {18'h00000, thr_q};
                REG_STATUS: O_WB_DAT <= status;
                REG_SAMPLE: O_WB_DAT <= {proc_q, out_q};
                default:    O_WB_DAT <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            thr_q <= CLIP_THR_RST;
        end else if (wb_hit && I_WB_WE && I_WB_ADR == REG_CTRL) begin
            if (I_WB_SEL[0]) thr_q[7:0]  <= I_WB_DAT[7:0];
            if (I_WB_SEL[1]) thr_q[13:8] <= I_WB_DAT[13:8];
        end
    end

endmodule
`default_nettype wire

// ===== src/ecmc_pkg.sv
// Constants, types and mu-law helpers for the echo canceler mode control.
// Assumes a 10 MHz system clock and a serial bit clock from the codec.
// Behaviour
// - Clip forces tx output minimum below -54 dBm0
// - Clip input high enables; slave holds it low
// - Control inputs latched at interrupt fall, reset release
// - Through mode passes rx and tx unchanged
// - Through mode clears all filter coefficients
// - Freeze input stops coefficient updates; slave holds low (not forced here: freeze follows its pin in either role)
// - Role select low master/single, high slave
// - Cascade of one master, six slaves, 209 ms
// - Delay reach 23 ms master, 31 ms slave
// - Processing runs from one main clock
// - Serial sample words are mu-law PCM
// - Interrupt falling edge starts one sample period
// - Interrupt ignored for 100 us after reset
// - Serial inputs sampled on bit clock falling edge
package ecmc_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned MAIN_CLK_HZ   = 19_200_000;
    localparam int unsigned SAMPLE_HZ     = 8_000;
    localparam int unsigned INIT_US       = 100;
    localparam int unsigned INIT_CYC      =
        (INIT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned INIT_W        = $clog2(INIT_CYC + 1);
    localparam int unsigned INIT_LATCH    = 2;
    localparam int unsigned MASTER_MS     = 23;
    localparam int unsigned SLAVE_MS      = 31;
    localparam int unsigned CASCADE_MS    = 209;
    localparam int unsigned MAX_SLAVES    = 6;
    localparam int unsigned MASTER_TAPS   = MASTER_MS * SAMPLE_HZ / 1000;
    localparam int unsigned SLAVE_TAPS    = SLAVE_MS * SAMPLE_HZ / 1000;
    localparam int          CLIP_DBM0     = -54;

    localparam int unsigned PCM_W   = 8;
    localparam int unsigned LIN_W   = 14;
    localparam int unsigned COEF_W  = 16;
    localparam int unsigned COEF_FR = 15;
    localparam int unsigned ACC_W   = 40;
    localparam int unsigned TAP_W   = 9;

    localparam logic [PCM_W-1:0] MU_IDLE      = 8'hFF;
    localparam logic [LIN_W-1:0] CLIP_THR_RST = 14'h0010;
    localparam logic [2:0]       LOAD_CYC     = 3'h4;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SAMPLE = 8'h08;
    localparam int unsigned ST_INIT   = 4;
    localparam int unsigned ST_BUSY   = 5;

    typedef struct packed {
        logic clip;
        logic through;
        logic freeze;
        logic slave;
    } ecmc_mode_t;

    localparam ecmc_mode_t MODE_RST = 4'h0;

    typedef struct packed {
        logic [PCM_W-1:0] tx;
        logic [PCM_W-1:0] rx;
    } ecmc_pcm_pair_t;

    typedef enum logic [1:0] {
        FIR_IDLE = 2'b00,
        FIR_RUN  = 2'b01,
        FIR_DONE = 2'b11
    } ecmc_fir_st_t;

    function automatic logic [LIN_W-1:0] ecmc_abs(
        input logic signed [LIN_W-1:0] v);
        return v[LIN_W-1] ? LIN_W'(-v) : LIN_W'(v);
    endfunction

    function automatic logic signed [LIN_W-1:0] ecmc_mu_expand(
        input logic [PCM_W-1:0] code);
        logic [7:0]  c;
        logic [13:0] mag;
        c = ~code;
        mag = ((14'({c[3:0], 1'b1}) + 14'h0020) << c[6:4]) - 14'h0021;
        return c[7] ? -$signed(mag) : $signed(mag);
    endfunction

    function automatic logic [PCM_W-1:0] ecmc_mu_compress(
        input logic signed [LIN_W-1:0] lin);
        logic [13:0] mag;
        logic [2:0]  ex;
        ex = 3'h0;
        mag = ecmc_abs(lin);
        if (mag > 14'h1FDE) mag = 14'h1FDE;
        mag = mag + 14'h0021;
        for (int i = 6; i <= 12; i++) begin
            if (mag[i]) ex = 3'(i - 5);
        end
        return ~{lin[13], ex, 4'(mag >> ({1'b0, ex} + 4'h1))};
    endfunction

endpackage

// ===== src/ecmc_fir.sv
// Adaptive FIR echo estimator, one tap per system clock.
// Assumes start pulses are spaced wider than the tap count.
`timescale 1ns/1ps
`default_nettype none
module ecmc_fir
    import ecmc_pkg::*;
#(
    parameter int unsigned              DEPTH = 256,
    parameter logic signed [COEF_W-1:0] STEP  = 16'sh0004
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    i_start,
    input  wire logic                    i_clear,
    input  wire logic                    i_freeze,
    input  wire logic [TAP_W-1:0]        i_taps,
    input  wire logic signed [LIN_W-1:0] i_x,
    input  wire logic signed [LIN_W-1:0] i_y,
    output logic signed [LIN_W-1:0]      o_err,
    output logic                         o_busy,
    output logic                         o_done
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic signed [COEF_W-1:0] coef_mem [DEPTH];
    logic signed [LIN_W-1:0]  hist_mem [DEPTH];
    ecmc_fir_st_t             st_q;
    logic [AW-1:0]            wptr_q;
    logic [TAP_W-1:0]         k_q;
    logic signed [ACC_W-1:0]  acc_q;
    logic signed [ACC_W-1:0]  est;
    logic signed [LIN_W-1:0]  y_q;
    logic [AW-1:0]            ka;
    logic signed [LIN_W-1:0]  xn;
    logic signed [LIN_W-1:0]  xo;
    logic signed [COEF_W-1:0] cn;

    assign ka     = k_q[AW-1:0];
    assign xn     = hist_mem[AW'(wptr_q - ka)];
    // Update pairs last period's error with last period's history
    assign xo     = hist_mem[AW'(wptr_q - ka - 1'b1)];
    assign cn     = coef_mem[ka];
    assign est    = acc_q >>> COEF_FR;
    assign o_busy = (st_q != FIR_IDLE);

    always_ff @(posedge clk) begin
        if (st_q == FIR_IDLE && i_start)
            hist_mem[AW'(wptr_q + 1'b1)] <= i_x;
    end

    always_ff @(posedge clk) begin
        if (rst || i_clear) begin
            for (int i = 0; i < DEPTH; i++) coef_mem[i] <= '0;
        end else if (st_q == FIR_RUN && !i_freeze && o_err != '0
                     && xo != '0) begin
            coef_mem[ka] <= (xo[LIN_W-1] == o_err[LIN_W-1]) ?
                            cn + STEP : cn - STEP;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= FIR_IDLE;
            wptr_q <= '0;
            k_q    <= '0;
            acc_q  <= '0;
            y_q    <= '0;
            o_err  <= '0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (st_q)
                FIR_IDLE: if (i_start) begin
                    wptr_q <= wptr_q + 1'b1;
                    k_q    <= '0;
                    acc_q  <= '0;
                    y_q    <= i_y;
                    st_q   <= FIR_RUN;
                end
                FIR_RUN: begin
                    acc_q <= acc_q + ACC_W'(cn) * ACC_W'(xn);
                    k_q   <= k_q + 1'b1;
                    if (k_q == i_taps - 1'b1) st_q <= FIR_DONE;
                end
                FIR_DONE: begin
                    if (ACC_W'(y_q) - est > ACC_W'(8191))
                        o_err <= 14'sh1FFF;
                    else if (ACC_W'(y_q) - est < -ACC_W'(8192))
                        o_err <= -14'sh2000;
                    else
                        o_err <= LIN_W'(ACC_W'(y_q) - est);
                    o_done <= 1'b1;
                    st_q   <= FIR_IDLE;
                end
                default: st_q <= FIR_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== src/ecmc_link.sv
// Serial side: shifts PCM words in and out on the codec bit clock.
// Assumes sync high during the first bit of each frame, MSB first.
`timescale 1ns/1ps
`default_nettype none
module ecmc_link
    import ecmc_pkg::*;
(
    input  wire logic           i_sck,
    input  wire logic           i_rst,
    input  wire logic           i_sync,
    input  wire logic           i_tx_in,
    input  wire logic           i_rx_in,
    input  wire ecmc_pcm_pair_t i_out,
    input  wire logic           i_out_tgl,
    output ecmc_pcm_pair_t      o_in,
    output logic                o_in_tgl,
    output logic                o_tx_out,
    output logic                o_rx_out
);
    logic [3:0]     cnt_q;
    ecmc_pcm_pair_t sh_q;
    ecmc_pcm_pair_t nxt;
    ecmc_pcm_pair_t obuf_q;
    ecmc_pcm_pair_t osh_q;
    logic [2:0]     otg_q;

    assign nxt = {sh_q.tx[6:0], i_tx_in, sh_q.rx[6:0], i_rx_in};

    always_ff @(negedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            cnt_q    <= '0;
            sh_q     <= '0;
            o_in     <= {MU_IDLE, MU_IDLE};
            o_in_tgl <= 1'b0;
        end else if (i_sync) begin
            cnt_q <= 4'h1;
            sh_q  <= {7'h00, i_tx_in, 7'h00, i_rx_in};
        end else if (cnt_q != '0) begin
            sh_q <= nxt;
            if (cnt_q == 4'(PCM_W - 1)) begin
                cnt_q    <= '0;
                o_in     <= nxt;
                o_in_tgl <= ~o_in_tgl;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // The output word is held long before its toggle arrives
    always_ff @(negedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            otg_q    <= '0;
            obuf_q   <= {MU_IDLE, MU_IDLE};
            osh_q    <= {MU_IDLE, MU_IDLE};
            o_tx_out <= 1'b1;
            o_rx_out <= 1'b1;
        end else begin
            otg_q <= {otg_q[1:0], i_out_tgl};
            if (otg_q[2] ^ otg_q[1]) obuf_q <= i_out;
            if (i_sync) begin
                o_tx_out <= obuf_q.tx[7];
                o_rx_out <= obuf_q.rx[7];
                osh_q    <= {obuf_q.tx[6:0], 1'b1, obuf_q.rx[6:0], 1'b1};
            end else begin
                o_tx_out <= osh_q.tx[7];
                o_rx_out <= osh_q.rx[7];
                osh_q    <= {osh_q.tx[6:0], 1'b1, osh_q.rx[6:0], 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/ecmc_checker.sv
// Port checks for ecmc_top, attached by bind to every instance.
// Assumes mode pins hold for 8 cycles around reset release and
// for 6 cycles after each interrupt fall.
`timescale 1ns/1ps
`default_nettype none
module ecmc_checker
    import ecmc_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_RESET,
    input wire logic       I_INT_N,
    input wire logic       I_CENTER_CLIP_CTL,
    input wire logic       I_THROUGH_MODE_CTL,
    input wire logic       I_COEF_FREEZE_CTL,
    input wire logic       I_ROLE_SELECT,
    input wire logic       I_WB_CYC,
    input wire logic       I_WB_STB,
    input wire logic       O_WB_ACK,
    input wire logic       O_LOAD_DETECT_N,
    input wire ecmc_mode_t O_MODE
);
    logic [9:0] rst_age_q;
    logic [3:0] int_age_q;
    ecmc_mode_t exp_mode;
    // Slave role forces clip off, so the expectation folds that in
    assign exp_mode = {I_CENTER_CLIP_CTL & ~I_ROLE_SELECT,
                       I_THROUGH_MODE_CTL, I_COEF_FREEZE_CTL, I_ROLE_SELECT};
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rst_age_q <= 10'h000;
        end else if (rst_age_q != 10'h3FF) begin
            rst_age_q <= rst_age_q + 10'h001;
        end
    end
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            int_age_q <= 4'hF;
        end else if (!I_INT_N) begin
            int_age_q <= 4'h0;
        end else if (int_age_q != 4'hF) begin
            int_age_q <= int_age_q + 4'h1;
        end
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);
    sequence wb_req;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence ldn_low4;
        !O_LOAD_DETECT_N [*4] ##1 O_LOAD_DETECT_N;
    endsequence
    chk_mode_stable: assert property (
        $changed(O_MODE) |-> (int_age_q <= 4'h8 || rst_age_q <= 10'h008))
        else $error("mode changed without a latch event");
    chk_init_ignore: assert property (
        (rst_age_q > 10'h008 && rst_age_q < 10'h3DE) |-> $stable(O_MODE))
        else $error("mode changed during initialisation");
    chk_reset_latch: assert property (
        rst_age_q == 10'h008 |-> O_MODE == exp_mode)
        else $error("pins not latched after reset release");
    chk_int_latch: assert property (
        $fell(I_INT_N) && rst_age_q == 10'h3FF |-> ##6 O_MODE == exp_mode)
        else $error("pins not latched after interrupt fall");
    chk_slave_noclip: assert property (
        O_MODE.slave |-> !O_MODE.clip)
        else $error("clip active in slave role");
    chk_ldn_pulse: assert property (
        $fell(O_LOAD_DETECT_N) |-> ldn_low4)
        else $error("load detect pulse not four cycles");
    chk_ack_next: assert property (
        wb_req |=> O_WB_ACK)
        else $error("bus request not acknowledged next cycle");
    chk_ack_pulse: assert property (
        O_WB_ACK |=> !O_WB_ACK)
        else $error("acknowledge longer than one cycle");
endmodule
bind ecmc_top ecmc_checker chk_u (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_INT_N(I_INT_N),
    .I_CENTER_CLIP_CTL(I_CENTER_CLIP_CTL),
    .I_THROUGH_MODE_CTL(I_THROUGH_MODE_CTL),
    .I_COEF_FREEZE_CTL(I_COEF_FREEZE_CTL), .I_ROLE_SELECT(I_ROLE_SELECT),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK),
    .O_LOAD_DETECT_N(O_LOAD_DETECT_N), .O_MODE(O_MODE));
`default_nettype wire

// ===== test/ecmc_codec_model.sv
// Codec model: one frame of mu-law words per call, link clock 6 ns.
// Assumes the caller spaces frames; the clock stands still between,
// so three idle bits lead each frame to let a pending output word in.
`timescale 1ns/1ps
`default_nettype none
module ecmc_codec_model (
    output logic      sck,
    output logic      sync,
    output logic      tx_in,
    output logic      rx_in,
    input  wire logic tx_out,
    input  wire logic rx_out
);
    initial begin
        sck = 1'b0;
        sync = 1'b0;
        tx_in = 1'b0;
        rx_in = 1'b1;
    end
    // Data moves on the rise so the falling sample edge sees it settled
    task automatic frame(input logic [7:0] t, input logic [7:0] r,
                         output logic [7:0] t_o, output logic [7:0] r_o);
        #7;
        for (int i = 0; i < 15; i++) begin
            #3 sck = 1'b1;
            if (i > 3 && i < 12) begin
                t_o[11-i] = tx_out;
                r_o[11-i] = rx_out;
            end
            sync = (i == 3);
            tx_in = (i > 2 && i < 11) ? t[10-i] : ~tx_in;
            rx_in = (i > 2 && i < 11) ? r[10-i] : ~rx_in;
            #3 sck = 1'b0;
        end
        tx_in = ~tx_in;
        rx_in = ~rx_in;
    endtask
endmodule
`default_nettype wire

// ===== test/ecmc_tb_top.sv
// Bench for ecmc_top: register bus, mode latching and data paths.
// Assumes the codec model and the bound checker; load detect drives
// the interrupt input as on the board.
`timescale 1ns/1ps
`default_nettype none
module ecmc_tb_top
    import ecmc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst, sck, sync, txi, rxi, ldn, txo, rxo;
    logic        clip, thr, frz, role, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat;
    ecmc_mode_t  mode;
    int          miscompares, checked;
    ecmc_top dut_u (
        .I_CLK(clk), .I_RESET(rst), .I_SCK(sck), .I_SYNC(sync),
        .I_TX_SERIAL_IN(txi), .I_RX_SERIAL_IN(rxi), .I_INT_N(ldn),
        .I_CENTER_CLIP_CTL(clip), .I_THROUGH_MODE_CTL(thr),
        .I_COEF_FREEZE_CTL(frz), .I_ROLE_SELECT(role),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .O_TX_SERIAL_OUT(txo), .O_RX_SERIAL_OUT(rxo),
        .O_LOAD_DETECT_N(ldn), .O_MODE(mode));
    ecmc_codec_model codec_u (.sck(sck), .sync(sync), .tx_in(txi),
        .rx_in(rxi), .tx_out(txo), .rx_out(rxo));
    always #50 clk = ~clk;
    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Ack is sampled on the rising edge; read data is taken at that edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            miscompares++;
            final_report();
        end
    endtask
    // Output pair of a period comes back in the frame after it
    task automatic pair(input logic [7:0] t, input logic [7:0] r,
                        output logic [7:0] t_o, output logic [7:0] r_o);
        logic [7:0] a, b;
        codec_u.frame(t, r, a, b);
        repeat (300) @(posedge clk);
        codec_u.frame(t, r, t_o, r_o);
        repeat (300) @(posedge clk);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic [7:0]  a, b;
        repeat (10) @(posedge clk);
        chk({28'h0, mode}, 32'h0000000E);
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk(q, 32'h00000010);
        wb(1'b1, REG_STATUS, 32'hFFFFFFFF, q);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q & 32'h0000001F, 32'h0000000E);
        wb(1'b0, 8'h0C, 32'h0, q);
        chk(q, 32'h0);
        thr <= 1'b0;
        clip <= 1'b0;
        codec_u.frame(8'h12, 8'h34, a, b);
        repeat (100) @(posedge clk);
        chk({28'h0, mode}, 32'h0000000E);
        repeat (1000) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q & 32'h00000010, 32'h00000010);
        $display("test reset done");
    endtask
    task automatic t_through();
        logic [31:0] q;
        logic [7:0]  a, b;
        thr <= 1'b1;
        frz <= 1'b0;
        pair(8'h5A, 8'hC3, a, b);
        chk({24'h0, a}, 32'h0000005A);
        chk({24'h0, b}, 32'h000000C3);
        chk({28'h0, mode}, 32'h00000004);
        wb(1'b0, REG_SAMPLE, 32'h0, q);
        chk(q, 32'h5AC35AC3);
        thr <= 1'b0;
        repeat (200) @(posedge clk);
        chk({28'h0, mode}, 32'h00000004);
        $display("test through done");
    endtask
    // Loud tx word over a silent rx: only the clip can make it idle
    task automatic t_modes();
        logic [31:0] q;
        logic [7:0]  a, b;
        wb(1'b1, REG_CTRL, 32'h00003FFF, q);
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk(q, 32'h00003FFF);
        for (int i = 0; i < 3; i++) begin
            clip <= (i != 1);
            frz <= (i == 0);
            role <= (i == 2);
            pair(8'h80, 8'hFF, a, b);
            chk({28'h0, mode}, {28'h0, (i == 0), 1'b0, (i == 0), (i == 2)});
            chk({31'h0, a === 8'hFF}, {31'h0, (i == 0)});
        end
        $display("test modes done");
    endtask
    initial begin
        rst = 1'b1;
        clip = 1'b1;
        thr = 1'b1;
        frz = 1'b1;
        role = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        miscompares = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_through();
        t_modes();
        final_report();
    end
endmodule
`default_nettype wire
